/* File: sdbb_pkg.sv */
package sdbb_pkg;

  // Clock period of ref_clk in nanoseconds.
  localparam int CLK_PERIOD_NS = 25;
  // Row precharge time in nanoseconds.
  localparam int T_RP_NS       = 20;
  // Least activate-to-precharge time in nanoseconds.
  localparam int T_RAS_NS      = 40;
  // Least times rounded up to whole clock cycles.
  localparam logic [7:0] RP_CYC  = 8'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RAS_CYC = 8'((T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Address pin layout.
  localparam int A_BANK = 11;                 // Bank select bit.
  localparam int A_AP   = 10;                 // Auto-precharge or precharge-all bit.
  localparam int ROW_W  = 10;                 // Row address bits 9..0.
  localparam int COL_W  = 8;                  // Column address bits 7..0.
  localparam int MEM_AW = 1 + ROW_W + COL_W;  // Bank, row and column of one word.

  // Mode register layout and codes.
  localparam int MODE_CL_LSB = 4;             // Latency field, bits 6..4.
  localparam int MODE_BT_BIT = 3;             // Burst type, 1 is interleaved.
  localparam int MODE_BL_LSB = 0;             // Burst length field, bits 2..0.
  localparam logic [2:0] CL2_CODE = 3'h2;     // Latency of two clocks.
  localparam logic [2:0] CL3_CODE = 3'h3;     // Latency of three clocks.
  localparam logic [2:0] BL_FULL  = 3'h7;     // Full page burst.
  localparam logic [6:0] MODE_RST = 7'h20;    // Latency 2, sequential, length 1.

  // Register offsets on the APB side and status field positions.
  localparam logic [7:0] ADDR_MODE  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam int STAT_ACT_LSB = 0;            // Two bank active bits.
  localparam int STAT_PRE_LSB = 2;            // Two bank precharging bits.
  localparam int STAT_RD_BIT  = 4;            // Read burst in progress.
  localparam int STAT_WR_BIT  = 5;            // Write burst in progress.

  // Commands decoded from the strobes.
  typedef enum logic [2:0] {
    C_NOP = 3'b000,
    C_ACT = 3'b001,
    C_RD  = 3'b010,
    C_WR  = 3'b011,
    C_PRE = 3'b100,
    C_BST = 3'b101,
    C_REF = 3'b110,
    C_MRS = 3'b111
  } sdbb_cmd_e;

  // Command pins as sampled on the rising edge.
  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [11:0] addr;
  } sdbb_pins_s;

  // APB request signals from the master.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } sdbb_apb_s;

  // Whole state of the device logic.
  typedef struct packed {
    logic [6:0]       mode;     // Latency, burst type and burst length.
    logic [1:0]       act;      // Bank holds an open row.
    logic [1:0][9:0]  row;      // Open row of each bank.
    logic [1:0][7:0]  pre_tmr;  // Cycles left until the bank is idle.
    logic [1:0][7:0]  ras_tmr;  // Cycles left until precharge is allowed.
    logic             on;       // A burst continues this cycle.
    logic             bwr;      // The burst is a write.
    logic             bbank;    // Bank of the burst.
    logic             bap;      // The burst ends in auto-precharge.
    logic [7:0]       bstart;   // Start column of the burst.
    logic [7:0]       bidx;     // Index of the word due this cycle.
    logic [2:0]       v;        // Read word issued one, two, three cycles ago.
    logic [15:0]      dq2;      // Read data two cycles after issue.
    logic [15:0]      dq3;      // Read data three cycles after issue.
    logic [1:0]       md1;      // Byte masks one cycle old.
    logic [1:0]       md2;      // Byte masks two cycles old.
    logic [31:0]      prdata;   // Read data for the APB access phase.
    logic             slverr;   // Address of the pending APB access is unmapped.
  } sdbb_state_s;

  localparam sdbb_state_s ST_RST = '{mode: MODE_RST, default: '0};

  // Decodes chip select and the three strobes into a command.
  function automatic sdbb_cmd_e decode_cmd(input sdbb_pins_s p);
    decode_cmd = C_NOP;
    if (!p.cs_n) begin
      unique case ({p.ras_n, p.cas_n, p.we_n})
        3'b011: decode_cmd = C_ACT;
        3'b101: decode_cmd = C_RD;
        3'b100: decode_cmd = C_WR;
        3'b010: decode_cmd = C_PRE;
        3'b110: decode_cmd = C_BST;
        3'b001: decode_cmd = C_REF;
        3'b000: decode_cmd = C_MRS;
        3'b111: decode_cmd = C_NOP;
      endcase
    end
  endfunction

  // Gives the wrap mask of a burst length code; reserved codes act as length 1.
  function automatic logic [7:0] bl_last(input logic [2:0] bl);
    case (bl)
      3'h1:    bl_last = 8'h01;
      3'h2:    bl_last = 8'h03;
      3'h3:    bl_last = 8'h07;
      default: bl_last = 8'h00;
    endcase
  endfunction

  // Column of burst word idx, sequential or interleaved within the wrap boundary.
  function automatic logic [7:0] burst_col(input logic [7:0] start, input logic [7:0] idx,
                                           input logic [6:0] mode);
    logic [7:0] m;
    m = bl_last(mode[MODE_BL_LSB +: 3]);
    if (mode[MODE_BL_LSB +: 3] == BL_FULL) begin
      burst_col = start + idx;
    end else if (mode[MODE_BT_BIT]) begin
      burst_col = (start & ~m) | ((start ^ idx) & m);
    end else begin
      burst_col = (start & ~m) | ((start + idx) & m);
    end
  endfunction

endpackage

/* File: sdbb_store.sv */
`timescale 1ns/1ps
// Word array with byte-lane writes and a registered read port.
module sdbb_store #(
  parameter int AW = 19,  // Bank, row and column bits.
  parameter int DW = 16   // Word width, two byte lanes.
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [1:0]    be,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic [DW-1:0]      rdata
);

  // Storage cells of both banks.
  logic [DW-1:0] mem [2**AW];

  // Writes the enabled lanes and reads the addressed word one cycle later.
  always_ff @(posedge clk) begin
    if (we && be[0]) begin
      mem[addr][DW/2-1:0] <= wdata[DW/2-1:0];
    end
    if (we && be[1]) begin
      mem[addr][DW-1:DW/2] <= wdata[DW-1:DW/2];
    end
    rdata <= mem[addr];
  end

endmodule

/* File: sdbb_device.sv */
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module sdbb_device (
  input  wire logic                ref_clk,          // Device clock.
  input  wire logic                reset,            // Synchronous, active high.
  input  wire sdbb_pkg::sdbb_pins_s pins,            // Select, strobes and address.
  input  wire logic                upper_byte_mask,  // Masks bits 15..8.
  input  wire logic                lower_byte_mask,  // Masks bits 7..0.
  input  wire logic [15:0]         dq_in,            // Data pins as seen by the device.
  output logic [15:0]              dq_out,           // Read data driven onto the pins.
  output logic [1:0]               dq_oe,            // Per-lane drive enable, lane 1 is upper.
  input  wire sdbb_pkg::sdbb_apb_s apb,              // APB request.
  output logic [31:0]              prdata,           // APB read data.
  output logic                     pready,           // APB ready.
  output logic                     pslverr           // APB error on unmapped address.
);
  import sdbb_pkg::*;

  sdbb_state_s     st_r;       // Registered state.
  sdbb_state_s     st_nxt;     // Next state.
  sdbb_cmd_e       cmd;        // Command of this cycle.
  logic            bank;       // Bank addressed by the command.
  logic [1:0]      pre_sel;    // Banks hit by a precharge command.
  logic            rw_ok;      // Read or write to an open bank.
  logic            cut;        // The running burst is stopped this cycle.
  logic            issue;      // A burst word is read or written this cycle.
  logic            last;       // The word of this cycle ends the burst.
  logic            ap_fire;    // Auto-precharge is scheduled this cycle.
  logic [7:0]      cur_idx;    // Burst index in use this cycle.
  logic [7:0]      col;        // Column of the word of this cycle.
  logic            cl3;        // Latency of three clocks selected.
  logic            full;       // Full page burst selected.
  logic            drv;        // Drivers wanted before byte masking.
  logic            out_valid;  // A read word is on the pins.
  logic            st_we;      // Array write strobe.
  logic [1:0]      st_be;      // Array byte enables.
  logic [MEM_AW-1:0] st_addr;  // Array word address.
  logic [15:0]     mem_q;      // Array read data.
  logic [31:0]     stat_word;  // Status register contents.
  logic            setup;      // APB setup phase.
  logic            access;     // APB access phase.

  assign cmd  = decode_cmd(pins);
  assign bank = pins.addr[A_BANK];
  assign cl3  = st_r.mode[MODE_CL_LSB +: 3] == CL3_CODE;
  assign full = st_r.mode[MODE_BL_LSB +: 3] == BL_FULL;
  assign setup  = apb.psel && !apb.penable;
  assign access = apb.psel && apb.penable;

  // Drivers turn on one cycle before the first word and stay on through the last.
  assign drv       = cl3 ? (st_r.v[2] | st_r.v[1]) : (st_r.v[1] | st_r.v[0]);
  assign out_valid = cl3 ? st_r.v[2] : st_r.v[1];
  // Masks seen two cycles ago close their lane; the controller relies on this in writes.
  assign dq_oe  = {2{drv}} & ~st_r.md2;
  assign dq_out = cl3 ? st_r.dq3 : st_r.dq2;

  // APB outputs: zero wait states, data taken from the setup phase.
  assign pready  = 1'b1;
  assign prdata  = st_r.prdata;
  assign pslverr = access && st_r.slverr;

  // Status shows bank states and the kind of burst in progress.
  always_comb begin
    stat_word = 32'h0;
    stat_word[STAT_ACT_LSB +: 2] = st_r.act;
    stat_word[STAT_PRE_LSB]     = st_r.pre_tmr[0] != 8'h00;
    stat_word[STAT_PRE_LSB + 1] = st_r.pre_tmr[1] != 8'h00;
    stat_word[STAT_RD_BIT] = st_r.on && !st_r.bwr;
    stat_word[STAT_WR_BIT] = st_r.on && st_r.bwr;
  end

  // Computes bank, burst, data pipeline and register updates.
  always_comb begin
    st_nxt = st_r;
    // Timers count down to zero.
    for (int b = 0; b < 2; b++) begin
      if (st_r.pre_tmr[b] != 8'h00) begin
        st_nxt.pre_tmr[b] = st_r.pre_tmr[b] - 8'h01;
      end
      if (st_r.ras_tmr[b] != 8'h00) begin
        st_nxt.ras_tmr[b] = st_r.ras_tmr[b] - 8'h01;
      end
    end
    // An idle bank whose precharge has finished opens the given row.
    if (cmd == C_ACT && !st_r.act[bank] && st_r.pre_tmr[bank] == 8'h00) begin
      st_nxt.act[bank]     = 1'b1;
      st_nxt.row[bank]     = pins.addr[ROW_W-1:0];
      st_nxt.ras_tmr[bank] = RAS_CYC - 8'h01;
    end
    // Bit 10 widens a precharge to both banks and bank select is then ignored.
    pre_sel = pins.addr[A_AP] ? 2'b11 : (bank ? 2'b10 : 2'b01);
    if (cmd == C_PRE) begin
      for (int b = 0; b < 2; b++) begin
        // Precharge is taken only once the active time has run out.
        if (pre_sel[b] && st_r.act[b] && st_r.ras_tmr[b] == 8'h00) begin
          st_nxt.act[b]     = 1'b0;
          st_nxt.pre_tmr[b] = RP_CYC - 8'h01;
        end
      end
    end
    // Reads and writes to a closed bank are ignored.
    rw_ok = (cmd == C_RD || cmd == C_WR) && st_r.act[bank];
    // Same-bank precharge and burst stop end the burst; other-bank precharge does not.
    cut = (cmd == C_PRE && pre_sel[st_r.bbank]) || cmd == C_BST;
    if (rw_ok) begin
      // A new command replaces the running burst from its own cycle.
      st_nxt.bwr    = cmd == C_WR;
      st_nxt.bbank  = bank;
      st_nxt.bstart = pins.addr[COL_W-1:0];
      st_nxt.bap    = pins.addr[A_AP] && !full;
    end
    cur_idx = rw_ok ? 8'h00 : st_r.bidx;
    issue   = rw_ok || (st_r.on && !cut);
    col     = burst_col(st_nxt.bstart, cur_idx, st_r.mode);
    // Length ends a burst; a full page one wraps over 256 columns until stopped.
    last        = issue && !full && cur_idx == bl_last(st_r.mode[MODE_BL_LSB +: 3]);
    st_nxt.on   = issue && !last;
    st_nxt.bidx = cur_idx + 8'h01;
    // Auto-precharge starts the cycle after the last issue, one clock past the
    // last write word and one or two clocks before the last read word.
    ap_fire = last && st_nxt.bap;
    if (ap_fire) begin
      st_nxt.act[st_nxt.bbank]     = 1'b0;
      st_nxt.pre_tmr[st_nxt.bbank] = RP_CYC;
    end
    // Read issue pipeline and data delay stages.
    st_nxt.v   = {st_r.v[1:0], issue && !st_nxt.bwr};
    st_nxt.dq2 = st_r.v[0] ? mem_q : 16'h0000;
    st_nxt.dq3 = st_r.dq2;
    // Read masks travel two stages before they reach the drivers.
    st_nxt.md1 = {upper_byte_mask, lower_byte_mask};
    st_nxt.md2 = st_r.md1;
    // APB read data and error are prepared in the setup phase.
    if (setup) begin
      st_nxt.slverr = apb.paddr != ADDR_MODE && apb.paddr != ADDR_STAT;
      st_nxt.prdata = apb.paddr == ADDR_MODE ? {25'h0, st_r.mode}
                    : (apb.paddr == ADDR_STAT ? stat_word : 32'h0);
    end
    // A mode write keeps the old latency when the new code is reserved.
    if (access && apb.pwrite && apb.paddr == ADDR_MODE) begin
      st_nxt.mode[3:0] = apb.pwdata[3:0];
      if (apb.pwdata[6:4] == CL2_CODE || apb.pwdata[6:4] == CL3_CODE) begin
        st_nxt.mode[6:4] = apb.pwdata[6:4];
      end
    end
  end

  // Array port: unmasked lanes of a write word are stored in the issue cycle.
  assign st_we   = issue && st_nxt.bwr;
  assign st_be   = ~{upper_byte_mask, lower_byte_mask};
  assign st_addr = {st_nxt.bbank, st_r.row[st_nxt.bbank], col};

  // Registers the whole state.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Holds the cell contents of both banks.
  sdbb_store #(
    .AW (MEM_AW),
    .DW (16)
  ) u_store (
    .clk   (ref_clk),
    .we    (st_we),
    .be    (st_be),
    .addr  (st_addr),
    .wdata (dq_in),
    .rdata (mem_q)
  );

  // Checks of the pin behaviour.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  logic act_ok;  // Activate that will be taken.
  logic rd_ok;   // Read that will be taken.
  assign act_ok = cmd == C_ACT && !st_r.act[bank] && st_r.pre_tmr[bank] == 8'h00;
  assign rd_ok  = rw_ok && cmd == C_RD;

  // Tail of a read cut at latency 2: one more word, then silence.
  sequence s_cut_tail2;
    ##1 out_valid ##1 !out_valid;
  endsequence

  property p_row_latch;
    act_ok |=> st_r.act[$past(bank)] && st_r.row[$past(bank)] == $past(pins.addr[9:0]);
  endproperty
  a_row_latch: assert property (p_row_latch)
    else $error("activate did not open the given row");

  property p_bank_sel;
    rw_ok |-> st_addr[MEM_AW-1] == pins.addr[A_BANK];
  endproperty
  a_bank_sel: assert property (p_bank_sel)
    else $error("burst word went to the wrong bank");

  property p_ap_full;
    rw_ok && full |=> !st_r.bap;
  endproperty
  a_ap_full: assert property (p_ap_full)
    else $error("auto-precharge kept in full page mode");

  property p_rd_first;
    rd_ok && !cl3 |-> ##2 out_valid;
  endproperty
  a_rd_first: assert property (p_rd_first)
    else $error("first read word not out after latency 2");

  property p_rd_drv;
    rd_ok && cl3 |-> ##2 (drv && !out_valid) ##1 out_valid;
  endproperty
  a_rd_drv: assert property (p_rd_drv)
    else $error("drivers not on one cycle before read data");

  property p_rd_mask;
    $rose(upper_byte_mask) |-> ##2 !dq_oe[1];
  endproperty
  a_rd_mask: assert property (p_rd_mask)
    else $error("upper mask did not close the lane two clocks later");

  property p_wr_first;
    rw_ok && cmd == C_WR |-> st_we && st_addr[COL_W-1:0] == pins.addr[COL_W-1:0];
  endproperty
  a_wr_first: assert property (p_wr_first)
    else $error("write word not stored in the command cycle");

  property p_wr_mask;
    st_we |-> st_be == ~{upper_byte_mask, lower_byte_mask};
  endproperty
  a_wr_mask: assert property (p_wr_mask)
    else $error("write mask not applied in the same cycle");

  property p_ap_start;
    ap_fire |=> !st_r.act[st_r.bbank] && st_r.pre_tmr[st_r.bbank] == RP_CYC;
  endproperty
  a_ap_start: assert property (p_ap_start)
    else $error("auto-precharge did not start after the last word");

  property p_pre_all;
    cmd == C_PRE && pins.addr[A_AP] && st_r.act == 2'b11 && st_r.ras_tmr == 16'h0000
      |=> st_r.act == 2'b00;
  endproperty
  a_pre_all: assert property (p_pre_all)
    else $error("precharge all left a bank open");

  property p_rd_cut;
    cut && st_r.on && !st_r.bwr && !cl3 |-> s_cut_tail2;
  endproperty
  a_rd_cut: assert property (p_rd_cut)
    else $error("read output after precharge ran for the wrong time");

  property p_wr_cut;
    cut && st_r.on && st_r.bwr |-> !st_we;
  endproperty
  a_wr_cut: assert property (p_wr_cut)
    else $error("write stored in the precharge cycle");

endmodule

/* File: sdbb_ctl_model.sv */
`timescale 1ns/1ps
// Memory controller model: drives the command pins, byte masks and data pins.
module sdbb_ctl_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] dq_out,
  input  wire logic [1:0]  dq_oe,
  output sdbb_pkg::sdbb_pins_s pins,
  output logic [1:0]       mask,
  output logic [15:0]      dq_in
);
  import sdbb_pkg::*;
  logic [15:0] drv;     // Word driven by the controller.
  logic        drv_on;  // Controller drives the data pins.
  logic [15:0] last;    // Level of the pins one cycle ago.
  logic [15:0] lane;    // Lanes the device drives.
  assign lane = {{8{dq_oe[1]}}, {8{dq_oe[0]}}};
  // A floating pin shows the inverse of its last level, so stale data never matches.
  assign dq_in = drv_on ? drv : ((dq_out & lane) | (~last & ~lane));
  // Keeps the last pin level for the floating pattern.
  always @(posedge ref_clk) begin
    last <= dq_in;
  end
  // Idle pins at time zero.
  initial begin
    pins = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, addr: 12'h000};
    mask = 2'b00;
    drv = 16'h0000;
    drv_on = 1'b0;
    last = 16'h0000;
  end
  // Places one command for one cycle; rel low leaves room for a command right after.
  task automatic cmd(input logic [2:0] rcw, input logic [11:0] a, input logic rel = 1'b1);
    pins <= '{cs_n: 1'b0, ras_n: rcw[2], cas_n: rcw[1], we_n: rcw[0], addr: a};
    @(posedge ref_clk);
    if (rel) begin
      pins <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, addr: 12'h000};
    end
  endtask
  // Drives or releases the data pins and sets both byte masks.
  task automatic put(input logic [15:0] d, input logic on, input logic [1:0] m);
    drv <= d;
    drv_on <= on;
    mask <= m;
  endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
// Self-checking bench: device logic driven through the controller model and APB.
module testbench;
  import sdbb_pkg::*;
  localparam logic [2:0] K_ACT = 3'b011;  // Strobe levels ras, cas, we.
  localparam logic [2:0] K_RD  = 3'b101;
  localparam logic [2:0] K_WR  = 3'b100;
  localparam logic [2:0] K_PRE = 3'b010;
  localparam logic [2:0] K_BST = 3'b110;
  logic        ref_clk = 1'b0;
  logic        reset   = 1'b1;
  sdbb_apb_s   apb     = '0;
  sdbb_pins_s  pins;
  logic [1:0]  mask;     // Bit 1 masks the upper lane.
  logic [15:0] dq_in;
  logic [15:0] dq_out;
  logic [1:0]  dq_oe;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          fails    = 0;
  int          compares = 0;
  logic [1:0]  nm [4]   = '{default: 2'b00};  // No masking.
  always #12.5 ref_clk = ~ref_clk;
  sdbb_device dut (.ref_clk(ref_clk), .reset(reset), .pins(pins),
    .upper_byte_mask(mask[1]), .lower_byte_mask(mask[0]), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .apb(apb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  sdbb_ctl_model ctl (.ref_clk(ref_clk), .dq_out(dq_out), .dq_oe(dq_oe), .pins(pins),
    .mask(mask), .dq_in(dq_in));
  // Prints the verdict and ends the run.
  task automatic conclude();
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Compares one value and reports a mismatch.
  task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, ex, got);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] rd, output logic err);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk);
    apb.penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb <= '0;
    @(posedge ref_clk);
  endtask
  // Reads a register and checks data and error flag.
  task automatic rreg(input string what, input logic [7:0] a, input logic [31:0] ex,
                      input logic ex_err);
    logic [31:0] rd;
    logic        e;
    apb_xfer(1'b0, a, 32'h0, rd, e);
    chk(what, ex, rd);
    chk(what, 32'(ex_err), 32'(e));
  endtask
  // Writes a register.
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    apb_xfer(1'b1, a, d, rd, e);
  endtask
  // Write command with n data words, the first in the command cycle.
  task automatic wr(input logic [11:0] a, input int n, input logic [15:0] w[4],
                    input logic [1:0] m[4]);
    ctl.put(w[0], 1'b1, m[0]);
    ctl.cmd(K_WR, a);
    for (int i = 1; i < n; i++) begin
      ctl.put(w[i], 1'b1, m[i]);
      @(posedge ref_clk);
    end
  endtask
  // Releases the data pins and masks, then waits k cycles.
  task automatic idle(input int k);
    ctl.put(16'h0000, 1'b0, 2'b00);
    repeat (k) @(posedge ref_clk);
  endtask
  // Read command, then checks drive enables and n words; mk[2], mk[3] mask words 2, 3.
  task automatic rd_chk(input logic [11:0] a, input int cl, input int n,
                        input logic [15:0] ex[4], input logic [1:0] mk[4]);
    logic [15:0] ln;
    ctl.cmd(K_RD, a);
    // Only a latency of three leaves a cycle with the drivers still off.
    for (int k = 2; k < cl; k++) begin
      @(negedge ref_clk);
      chk("oe before", 32'h0, 32'(dq_oe));
      @(posedge ref_clk);
    end
    @(negedge ref_clk);
    chk("oe early", 32'h3, 32'(dq_oe));
    @(posedge ref_clk);
    ctl.put(16'h0000, 1'b0, mk[2]);
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      ln = {{8{~mk[i][1]}}, {8{~mk[i][0]}}};
      chk("read oe", {30'h0, ~mk[i]}, 32'(dq_oe));
      chk("read word", 32'(ex[i] & ln), 32'(dq_out & ln));
      @(posedge ref_clk);
      ctl.put(16'h0000, 1'b0, (i == 0) ? mk[3] : 2'b00);
    end
    @(negedge ref_clk);
    chk("oe after", 32'h0, 32'(dq_oe));
    @(posedge ref_clk);
  endtask
  // Reset values, unmapped address, read-only status, reserved latency code.
  task automatic s_regs();
    rreg("mode rst", ADDR_MODE, 32'h20, 1'b0);
    rreg("unmapped", 8'h08, 32'h0, 1'b1);
    wreg(ADDR_STAT, 32'hff);
    rreg("stat ro", ADDR_STAT, 32'h0, 1'b0);
    wreg(ADDR_MODE, 32'h42);
    rreg("mode cl4", ADDR_MODE, 32'h22, 1'b0);
    wreg(ADDR_MODE, 32'h22);
    rreg("mode cl2", ADDR_MODE, 32'h22, 1'b0);
  endtask
  // An interrupted write and a masked write, read back at both latencies, with read masks at latency 2 only.
  task automatic s_wr_rd();
    ctl.cmd(K_ACT, 12'h005);
    @(posedge ref_clk);
    wr(12'h002, 2, '{16'ha1b1, 16'ha2b2, 16'h0, 16'h0}, nm);
    wr(12'h002, 4, '{16'hc1d1, 16'hc2d2, 16'hc3d3, 16'hc4d4},
       '{2'b01, 2'b10, 2'b00, 2'b00});
    idle(2);
    rd_chk(12'h302, 2, 4, '{16'hc1b1, 16'ha2d2, 16'hc3d3, 16'hc4d4},
           '{2'b00, 2'b00, 2'b10, 2'b01});
    wreg(ADDR_MODE, 32'h31);
    rd_chk(12'h000, 3, 2, '{16'hc3d3, 16'hc4d4, 16'h0, 16'h0}, nm);
  endtask
  // Precharge cuts a length-8 read after two words.
  task automatic s_cut();
    wreg(ADDR_MODE, 32'h23);
    fork
      rd_chk(12'h000, 2, 2, '{16'hc3d3, 16'hc4d4, 16'h0, 16'h0}, nm);
      begin
        repeat (2) @(posedge ref_clk);
        ctl.cmd(K_PRE, 12'h000);
      end
    join
    rreg("stat cut", ADDR_STAT, 32'h0, 1'b0);
  endtask
  // Bank select, early precharge refused, precharge of both banks, reopening.
  task automatic s_banks();
    ctl.cmd(K_ACT, 12'h800, 1'b0);
    ctl.cmd(K_PRE, 12'h800);
    rreg("stat early", ADDR_STAT, 32'h2, 1'b0);
    ctl.cmd(K_ACT, 12'h005);
    rreg("stat both", ADDR_STAT, 32'h3, 1'b0);
    ctl.cmd(K_PRE, 12'h400, 1'b0);
    ctl.cmd(K_ACT, 12'h800);
    idle(2);
    rreg("stat pre all", ADDR_STAT, 32'h2, 1'b0);
  endtask
  // Auto-precharge on write and read, then a full page write ended by burst stop.
  task automatic s_auto();
    wreg(ADDR_MODE, 32'h22);
    ctl.cmd(K_ACT, 12'h005);
    @(posedge ref_clk);
    wr(12'h400, 4, '{16'h1e01, 16'h1e02, 16'h1e03, 16'h1e04}, nm);
    idle(3);
    rreg("stat wr ap", ADDR_STAT, 32'h2, 1'b0);
    ctl.cmd(K_ACT, 12'h005);
    @(posedge ref_clk);
    rd_chk(12'h400, 2, 4, '{16'h1e01, 16'h1e02, 16'h1e03, 16'h1e04}, nm);
    rreg("stat rd ap", ADDR_STAT, 32'h2, 1'b0);
    wreg(ADDR_MODE, 32'h27);
    ctl.cmd(K_ACT, 12'h005);
    @(posedge ref_clk);
    wr(12'h4fe, 4, '{16'hf0f0, 16'hf1f1, 16'hf2f2, 16'hf3f3}, nm);
    ctl.put(16'h0000, 1'b0, 2'b00);
    ctl.cmd(K_BST, 12'h000);
    rreg("stat full", ADDR_STAT, 32'h3, 1'b0);
    // A full page read runs on until the burst stop ends it.
    fork
      rd_chk(12'h000, 2, 2, '{16'hf2f2, 16'hf3f3, 16'h0, 16'h0}, nm);
      begin
        repeat (2) @(posedge ref_clk);
        ctl.cmd(K_BST, 12'h000);
      end
    join
    wreg(ADDR_MODE, 32'h21);
    rd_chk(12'h000, 2, 2, '{16'hf2f2, 16'hf3f3, 16'h0, 16'h0}, nm);
  endtask
  // A write cuts a read; masks held over the read keep its word off the pins.
  task automatic s_rd_wr();
    ctl.put(16'h0000, 1'b0, 2'b11);
    @(posedge ref_clk);
    ctl.cmd(K_RD, 12'h000, 1'b0);
    fork
      wr(12'h000, 2, '{16'h7a7a, 16'h7b7b, 16'h0, 16'h0}, nm);
      repeat (2) begin
        @(negedge ref_clk);
        chk("oe under write", 32'h0, 32'(dq_oe));
      end
    join
    idle(1);
    rd_chk(12'h000, 2, 2, '{16'h7a7a, 16'h7b7b, 16'h0, 16'h0}, nm);
  endtask
  // Main sequence after 12 cycles of reset.
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    s_regs();
    s_wr_rd();
    s_cut();
    s_banks();
    s_auto();
    s_rd_wr();
    conclude();
  end
  // Watchdog against a hang; the tests need about 150 cycles.
  initial begin
    repeat (4000) @(posedge ref_clk);
    fails++;
    $display("MISMATCH watchdog expected finish seen hang");
    conclude();
  end
endmodule
